//--- verilog/adk_pkg.sv
// Purpose: shared constants and types for the second converter control block
// Assumes: registers sit on a 32-bit apb bus, one aligned word each
// Notes: printed offsets are register indexes; byte address is index times four
package adk_pkg;
    // register indexes and apb geometry
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_CTRL_ONE = 8'h97;
    localparam logic [7:0] IDX_MODE_A = 8'hc0;
    localparam logic [7:0] IDX_MODE_B = 8'ha1;
    localparam logic [7:0] IDX_INPUT_SEL = 8'ha3;
    localparam logic [7:0] IDX_FOURTH_RES = 8'hf0;
    localparam logic [7:0] IDX_STATUS = 8'hf1;
    // field positions that the write path needs by number
    localparam int CTRL_FLAG_POS = 3;
    localparam int CTRL_EN_POS = 2;
    localparam int MODA_BND_POS = 7;
    localparam int MODB_DIV_POS = 5;
    localparam int MODB_DAC_POS = 3;
    localparam int INSEL_POS = 4;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] MODA_RST = 4'h0;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [3:0] INSEL_RST = 4'h0;
    localparam logic [7:0] RES_RST = 8'h00;
    // start mode encodings of the control register
    typedef enum logic [1:0] {
        ADK_ST_TIMER = 2'h0,
        ADK_ST_NOW = 2'h1,
        ADK_ST_EDGE = 2'h2,
        ADK_ST_DUAL = 2'h3
    } adk_start_t;
    // sequencer states
    typedef enum logic [1:0] {
        ADK_S_IDLE = 2'h0,
        ADK_S_BUSY = 2'h1,
        ADK_S_RUN = 2'h2
    } adk_state_t;
    // first control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic boundary_irq_enable;
        logic complete_irq_enable;
        logic timer_trigger_select;
        logic edge_polarity;
        logic conversion_complete_flag;
        logic converter_enable;
        adk_start_t start_mode;
    } adk_ctrl_t;
    // upper nibble of the first mode register
    typedef struct packed {
        logic boundary_flag;
        logic scan_continuous_select;
        logic fixed_continuous_select;
        logic single_conversion_select;
    } adk_moda_t;
endpackage

//--- verilog/adk_clkdiv.sv
// Purpose: converter clock divider, one tick every divisor core clocks
// Assumes: divisor is the field value plus one
// Notes: counter is held at zero while disabled so the first tick is aligned
`timescale 1ns/1ps
module adk_clkdiv #(
    parameter int DIV_W = 3
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_en,
    input wire logic [DIV_W-1:0] i_div,
    output logic o_tick
);
    initial begin
        if (DIV_W < 1 || DIV_W > 8) begin
            $error("adk_clkdiv: DIV_W out of range");
        end
    end

    logic [DIV_W-1:0] cnt_q; // cycles since last tick
    logic last_w; // terminal count reached
    assign last_w = (cnt_q == i_div); // RULE4

    // counter wraps at the field value, giving field plus one cycles
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else if (!i_en) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_q <= last_w ? '0 : cnt_q + 1'b1; // RULE3
            o_tick <= last_w;
        end
    end
endmodule // adk_clkdiv

//--- verilog/adk_ctrl.sv
// Purpose: start, mode, flag, dac and divider control of the second converter
// Assumes: apb slave with zero wait states; analog core reports completion
// Notes: the analog core owns result sequencing and the boundary compare
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
// Contract
// RULE1 - dac drives fourth result value on pin
// RULE2 - dac output only while dac select set
// RULE3 - divider derives converter clock, ratio 1..8
// RULE4 - divider field plus one is divisor
// RULE5 - selected pins lose digital input when enabled
// RULE6 - keeps converting in idle, completion wakes
// RULE7 - no operation in power-down modes
// RULE8 - mode 00 starts on timer overflow if selected
// RULE9 - timer overflows ignored while converting
// RULE10 - writing mode 01 starts at once
// RULE11 - mode 10 starts on chosen pin edge
// RULE12 - pin edges ignored while converting
// RULE13 - mode 11 starts both converters together
// RULE14 - enable bit gates converter and dac
// RULE15 - complete flag set by hardware, software clears
// RULE16 - edge polarity: 0 falling, 1 rising
// RULE17 - complete flag with enable requests interrupt
// RULE18 - boundary flag with enable requests interrupt
// RULE19 - single conversion select bit
// RULE20 - fixed continuous select bit
// RULE21 - scan continuous select bit
// RULE22 - no mode bits means single step
// RULE23 - boundary flag set on out-of-range result
// RULE24 - control and mode nibble reset to zero
// RULE25 - boundary flag sticky until written zero
module adk_ctrl (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [adk_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_timer0_ovf,
    input wire logic i_edge_trigger_pin,
    input wire logic i_conv_done,
    input wire logic i_bound_hit,
    input wire logic i_irq_global,
    input wire logic i_idle,
    input wire logic i_pdown,
    output logic o_conv_start,
    output logic o_dual_start,
    output logic [2:0] o_conv_mode,
    output logic o_busy,
    output logic o_adc_tick,
    output logic o_irq,
    output logic o_wake,
    output logic o_dac_en,
    output logic [7:0] o_dac_value,
    output logic [3:0] o_dig_in_off
);
    // register state
    adk_pkg::adk_ctrl_t ctrl_q; // first control register
    adk_pkg::adk_ctrl_t ctrl_d;
    adk_pkg::adk_moda_t moda_q; // first mode register, upper nibble
    adk_pkg::adk_moda_t moda_d;
    logic [2:0] div_q; // divider field of the second mode register
    logic dac_sel_q; // dac mode select
    logic [3:0] insel_q; // input select, one bit per channel
    logic [7:0] res3_q; // fourth result register
    adk_pkg::adk_state_t state_q; // sequencer state
    adk_pkg::adk_state_t state_d;
    logic pin_q; // last sample of the trigger pin

    // apb address decode; low two bits must be zero for a word access
    logic [adk_pkg::ADDR_W-3:0] idx_w;
    logic aligned_w;
    logic sel_ctrl_w;
    logic sel_moda_w;
    logic sel_modb_w;
    logic sel_insel_w;
    logic sel_res_w;
    logic sel_stat_w;
    logic mapped_w;
    logic setup_w;
    logic acc_w;
    logic wr_w;
    assign idx_w = i_paddr[adk_pkg::ADDR_W-1:2];
    assign aligned_w = (i_paddr[1:0] == 2'h0);
    assign sel_ctrl_w = aligned_w && (idx_w == 10'(adk_pkg::IDX_CTRL_ONE));
    assign sel_moda_w = aligned_w && (idx_w == 10'(adk_pkg::IDX_MODE_A));
    assign sel_modb_w = aligned_w && (idx_w == 10'(adk_pkg::IDX_MODE_B));
    assign sel_insel_w = aligned_w && (idx_w == 10'(adk_pkg::IDX_INPUT_SEL));
    assign sel_res_w = aligned_w && (idx_w == 10'(adk_pkg::IDX_FOURTH_RES));
    assign sel_stat_w = aligned_w && (idx_w == 10'(adk_pkg::IDX_STATUS));
    assign mapped_w = sel_ctrl_w | sel_moda_w | sel_modb_w | sel_insel_w
                      | sel_res_w | sel_stat_w;
    assign setup_w = i_psel && !i_penable;
    // a transfer completes at the edge where pready is seen high
    assign acc_w = i_psel && i_penable && o_pready;
    assign wr_w = acc_w && i_pwrite;

    // read mux; reserved bits read as zero
    logic [7:0] rd_w;
    assign rd_w = sel_ctrl_w ? ctrl_q
                : sel_moda_w ? {moda_q, 4'h0}
                : sel_modb_w ? {div_q, 1'b0, dac_sel_q, 3'h0}
                : sel_insel_w ? {insel_q, 4'h0}
                : sel_res_w ? res3_q
                : sel_stat_w ? {6'h0, state_q}
                : 8'h00;

    // operating conditions
    logic operate_w; // enabled and not powered down
    logic cont_w; // a continuous mode is selected
    assign operate_w = ctrl_q.converter_enable && !i_pdown; // RULE7 RULE14
    assign cont_w = moda_q.scan_continuous_select
                    || moda_q.fixed_continuous_select; // RULE20 RULE21

    // start sources
    logic wr_ctrl_w;
    logic [1:0] wmode_w;
    logic imm_w;
    logic dual_w;
    logic tmr_w;
    logic rise_w;
    logic fall_w;
    logic edge_w;
    logic trig_w;
    logic start_w;
    logic done_w;
    assign wr_ctrl_w = wr_w && sel_ctrl_w;
    assign wmode_w = i_pwdata[1:0];
    // immediate starts act on the write itself, with the enable being written
    assign imm_w = wr_ctrl_w && i_pwdata[adk_pkg::CTRL_EN_POS] && !i_pdown
                   && (wmode_w == adk_pkg::ADK_ST_NOW
                       || wmode_w == adk_pkg::ADK_ST_DUAL); // RULE10 RULE13
    assign dual_w = imm_w && (wmode_w == adk_pkg::ADK_ST_DUAL); // RULE13
    assign tmr_w = (ctrl_q.start_mode == adk_pkg::ADK_ST_TIMER)
                   && ctrl_q.timer_trigger_select && i_timer0_ovf; // RULE8
    assign rise_w = i_edge_trigger_pin && !pin_q;
    assign fall_w = !i_edge_trigger_pin && pin_q;
    assign edge_w = (ctrl_q.start_mode == adk_pkg::ADK_ST_EDGE)
                    && (ctrl_q.edge_polarity ? rise_w : fall_w); // RULE11 RULE16
    // triggers count only while nothing runs, so later ones are dropped
    assign trig_w = operate_w && (state_q == adk_pkg::ADK_S_IDLE)
                    && (tmr_w || edge_w); // RULE9 RULE12
    assign start_w = trig_w || imm_w;
    // idle mode does not gate completion; conversion carries on
    assign done_w = i_conv_done && operate_w
                    && (state_q != adk_pkg::ADK_S_IDLE); // RULE6

    // sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            adk_pkg::ADK_S_IDLE: begin
                if (start_w) begin
                    state_d = cont_w ? adk_pkg::ADK_S_RUN : adk_pkg::ADK_S_BUSY;
                end
            end
            adk_pkg::ADK_S_BUSY: begin
                // single conversion and single step (no mode bit) both stop at completion
                if (!operate_w || (done_w && !imm_w)) begin
                    state_d = adk_pkg::ADK_S_IDLE; // RULE19 RULE22
                end
            end
            adk_pkg::ADK_S_RUN: begin
                // continuous runs until disabled or the mode is left
                if (!operate_w || !cont_w) begin
                    state_d = adk_pkg::ADK_S_IDLE;
                end
            end
            default: begin
                state_d = adk_pkg::ADK_S_IDLE;
            end
        endcase
    end

    // control register next value; flag clears only on a written zero
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl_w) begin
            ctrl_d = adk_pkg::adk_ctrl_t'(i_pwdata[7:0]);
            ctrl_d.conversion_complete_flag = ctrl_q.conversion_complete_flag
                                              && i_pwdata[adk_pkg::CTRL_FLAG_POS];
        end
        // set wins over a clear in the same cycle
        if (done_w) begin
            ctrl_d.conversion_complete_flag = 1'b1; // RULE15
        end
    end

    // mode register a next value; boundary flag only set by hardware
    always_comb begin
        moda_d = moda_q;
        if (wr_w && sel_moda_w) begin
            moda_d = adk_pkg::adk_moda_t'(i_pwdata[7:4]);
            moda_d.boundary_flag = moda_q.boundary_flag
                                   && i_pwdata[adk_pkg::MODA_BND_POS]; // RULE25
        end
        if (i_bound_hit && operate_w) begin
            moda_d.boundary_flag = 1'b1; // RULE23
        end
    end

    // interrupt request from either enabled flag
    logic irq_w;
    assign irq_w = i_irq_global
                   && ((ctrl_q.complete_irq_enable && ctrl_q.conversion_complete_flag)
                       || (ctrl_q.boundary_irq_enable && moda_q.boundary_flag)); // RULE17 RULE18

    // registers with async reset to documented zero
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= adk_pkg::adk_ctrl_t'(adk_pkg::CTRL_RST); // RULE24
            moda_q <= adk_pkg::adk_moda_t'(adk_pkg::MODA_RST); // RULE24
            state_q <= adk_pkg::ADK_S_IDLE;
            pin_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            moda_q <= moda_d;
            state_q <= state_d;
            pin_q <= i_edge_trigger_pin;
        end
    end

    // software-only registers: divider, dac select, input select, dac value
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_q <= adk_pkg::DIV_RST;
            dac_sel_q <= 1'b0;
            insel_q <= adk_pkg::INSEL_RST;
            res3_q <= adk_pkg::RES_RST;
        end else begin
            if (wr_w && sel_modb_w) begin
                div_q <= i_pwdata[adk_pkg::MODB_DIV_POS +: 3]; // RULE4
                dac_sel_q <= i_pwdata[adk_pkg::MODB_DAC_POS];
            end
            if (wr_w && sel_insel_w) begin
                insel_q <= i_pwdata[adk_pkg::INSEL_POS +: 4];
            end
            if (wr_w && sel_res_w) begin
                res3_q <= i_pwdata[7:0];
            end
        end
    end

    // apb answer: data registered in setup, shown with pready in access
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= setup_w;
            o_pslverr <= setup_w && !mapped_w;
            o_prdata <= (setup_w && !i_pwrite) ? {24'h00_0000, rd_w} : 32'h0000_0000;
        end
    end

    // converter-facing outputs
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_conv_start <= 1'b0;
            o_dual_start <= 1'b0;
            o_conv_mode <= 3'h0;
            o_busy <= 1'b0;
            o_irq <= 1'b0;
            o_wake <= 1'b0;
            o_dac_en <= 1'b0;
            o_dac_value <= 8'h00;
        end else begin
            o_conv_start <= start_w;
            o_dual_start <= dual_w; // RULE13
            o_conv_mode <= {moda_q.scan_continuous_select,
                            moda_q.fixed_continuous_select,
                            moda_q.single_conversion_select}; // RULE19 RULE20 RULE21
            o_busy <= (state_d != adk_pkg::ADK_S_IDLE);
            o_irq <= irq_w;
            o_wake <= irq_w && i_idle; // RULE6
            // dac needs both its select and the converter enable
            o_dac_en <= dac_sel_q && operate_w; // RULE2 RULE14
            o_dac_value <= res3_q; // RULE1
        end
    end

    // digital input disconnect, one flop per analog pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_din
            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_dig_in_off[gi] <= 1'b0;
                end else begin
                    o_dig_in_off[gi] <= insel_q[gi] && ctrl_q.converter_enable; // RULE5
                end
            end
        end
    endgenerate

    // converter clock runs only while the converter may operate
    adk_clkdiv #(
        .DIV_W(3)
    ) u_div (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_en(operate_w), // RULE3 RULE7
        .i_div(div_q),
        .o_tick(o_adc_tick)
    );

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    property p_r1;
        (wr_w && sel_res_w) |-> ##2 (o_dac_value == $past(i_pwdata[7:0], 2));
    endproperty
    a_r1: assert property (p_r1) else $error("dac value not from result"); // RULE1

    property p_r2;
        o_dac_en |-> $past(dac_sel_q && ctrl_q.converter_enable && !i_pdown);
    endproperty
    a_r2: assert property (p_r2) else $error("dac on without select"); // RULE2

    property p_r7;
        o_conv_start |-> !$past(i_pdown);
    endproperty
    a_r7: assert property (p_r7) else $error("start in power-down"); // RULE7

    property p_r8;
        (trig_w && tmr_w && !wr_ctrl_w) |=> o_conv_start ##1 o_busy;
    endproperty
    a_r8: assert property (p_r8) else $error("timer start missed"); // RULE8

    property p_r9;
        (state_q == adk_pkg::ADK_S_BUSY && i_timer0_ovf && !imm_w)
            |=> !o_conv_start;
    endproperty
    a_r9: assert property (p_r9) else $error("timer retrigger taken"); // RULE9

    property p_r10;
        (wr_ctrl_w && wmode_w == 2'h1 && i_pwdata[2] && !i_pdown)
            |=> o_conv_start && !o_dual_start;
    endproperty
    a_r10: assert property (p_r10) else $error("immediate start missed"); // RULE10

    property p_r12;
        (state_q != adk_pkg::ADK_S_IDLE && edge_w && !imm_w) |=> !o_conv_start;
    endproperty
    a_r12: assert property (p_r12) else $error("edge retrigger taken"); // RULE12

    property p_r13;
        (wr_ctrl_w && wmode_w == 2'h3 && i_pwdata[2] && !i_pdown)
            |=> o_conv_start && o_dual_start;
    endproperty
    a_r13: assert property (p_r13) else $error("dual start missed"); // RULE13

    property p_r15;
        (ctrl_q.conversion_complete_flag && !(wr_ctrl_w && !i_pwdata[3]))
            |=> ctrl_q.conversion_complete_flag;
    endproperty
    a_r15: assert property (p_r15) else $error("complete flag lost"); // RULE15

    property p_r17;
        (done_w ##1 (i_irq_global && ctrl_q.complete_irq_enable)) |=> o_irq;
    endproperty
    a_r17: assert property (p_r17) else $error("completion irq missed"); // RULE17

    property p_r25;
        (moda_q.boundary_flag && !(wr_w && sel_moda_w && !i_pwdata[7]))
            |=> moda_q.boundary_flag;
    endproperty
    a_r25: assert property (p_r25) else $error("boundary flag lost"); // RULE25

    c_timer: cover property (trig_w && tmr_w ##1 o_conv_start);
    c_edge: cover property (trig_w && edge_w ##1 o_conv_start);
    c_dual: cover property (o_dual_start);
    c_wake: cover property (o_wake);
endmodule // adk_ctrl

//--- dv/adk_core_model.sv
// Purpose: behavioural analog core that answers the control block's start pulses
// Assumes: one conversion or set at a time, finishing after a settable delay
// Notes: the delay input lets a scenario pick a prompt or a slow answer
`timescale 1ns/1ps
module adk_core_model (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic [7:0] i_dly,
    input wire logic i_bound,
    output logic o_done,
    output logic o_bound
);
    // cycles left in the conversion now running, zero when quiet
    logic [7:0] cnt_q;

    // count down from each start, pulse done on the last cycle
    // a new start restarts the count, as a real core would restart its set
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= 8'h00;
            o_done <= 1'b0;
            o_bound <= 1'b0;
        end else begin
            o_done <= (cnt_q == 8'h01);
            // out of range result is reported together with completion
            o_bound <= (cnt_q == 8'h01) && i_bound;
            if (i_start) begin
                cnt_q <= i_dly;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule // adk_core_model

//--- dv/adk_ctrl_bench.sv
// Purpose: self-checking bench for the converter control block
// Assumes: zero wait apb slave, core model answers after a set delay
// Notes: one task per scenario; each judges its own results before returning
`timescale 1ns/1ps
module adk_ctrl_bench;
    logic i_mclk = 0;
    logic i_resetn = 0; // held low for the first ten cycles
    logic i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [adk_pkg::ADDR_W-1:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata;
    logic o_pready, o_pslverr, o_conv_start, o_dual_start, o_busy, o_adc_tick;
    logic o_irq, o_wake, o_dac_en;
    logic [2:0] o_conv_mode;
    logic [7:0] o_dac_value;
    logic [3:0] o_dig_in_off;
    logic i_timer0_ovf = 0, i_edge_trigger_pin = 1, i_irq_global = 0;
    logic i_idle = 0, i_pdown = 0;
    logic bnd_req = 0; // model reports an out of range result
    logic [7:0] dly = 8'h06; // model conversion time in cycles
    logic i_conv_done, i_bound_hit;
    int n_errors = 0, tests_run = 0, n_st = 0, n_du = 0, s;
    logic [31:0] rd; // last read data
    logic er; // last slave error

    always #12.5 i_mclk = ~i_mclk; // 40 MHz core clock

    adk_ctrl i_dut (.i_mclk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_timer0_ovf, .i_edge_trigger_pin,
        .i_conv_done, .i_bound_hit, .i_irq_global, .i_idle, .i_pdown, .o_conv_start,
        .o_dual_start, .o_conv_mode, .o_busy, .o_adc_tick, .o_irq, .o_wake, .o_dac_en,
        .o_dac_value, .o_dig_in_off);
    adk_core_model i_core (.i_mclk, .i_resetn, .i_start(o_conv_start), .i_dly(dly),
        .i_bound(bnd_req), .o_done(i_conv_done), .o_bound(i_bound_hit));

    // count start pulses so scenarios can tell how many conversions began
    always @(posedge i_mclk) begin
        if (o_conv_start === 1'b1) n_st++;
        if (o_dual_start === 1'b1) n_du++;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_psel <= 1;
        i_penable <= 0;
        i_pwrite <= w;
        i_paddr <= {2'b00, idx, 2'b00};
        i_pwdata <= {24'h0, d};
        @(posedge i_mclk);
        i_penable <= 1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            stop_test();
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(nm, rd, {24'h0, exp});
    endtask

    // wait for the sequencer to go idle, then let flags and irq land
    task automatic wait_idle();
        int n;
        n = 0;
        cyc(2);
        while (o_busy !== 1'b0 && n < 200) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 200) begin
            n_errors++;
            stop_test();
        end
        cyc(3);
    endtask

    // wait for the next divider tick; a tick that never comes ends the run
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_adc_tick !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            stop_test();
        end
    endtask

    task automatic t_reset();
        rdc("ctrl reset", 8'h97, 8'h00);
        rdc("mode_a reset", 8'hc0, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
        $display("test reset done");
    endtask

    task automatic t_now();
        s = n_st;
        wr(8'h97, 8'h05);
        wait_idle();
        chk("immediate start", n_st - s, 1);
        rdc("flag set", 8'h97, 8'h0d);
        wr(8'h97, 8'h0c);
        rdc("flag kept", 8'h97, 8'h0c);
        wr(8'h97, 8'h04);
        rdc("flag cleared", 8'h97, 8'h04);
        s = n_du;
        wr(8'h97, 8'h07);
        wait_idle();
        chk("dual start", n_du - s, 1);
        $display("test immediate done");
    endtask

    task automatic pulse_ovf();
        @(posedge i_mclk);
        i_timer0_ovf <= 1;
        @(posedge i_mclk);
        i_timer0_ovf <= 0;
    endtask

    task automatic t_trig();
        dly <= 8'h10; // slow answer keeps the core busy across a second trigger
        wr(8'h97, 8'h24);
        s = n_st;
        pulse_ovf();
        cyc(3);
        pulse_ovf();
        wait_idle();
        chk("timer start", n_st - s, 1);
        wr(8'h97, 8'h04);
        s = n_st;
        pulse_ovf();
        cyc(4);
        chk("stop mode", n_st - s, 0);
        wr(8'h97, 8'h06);
        s = n_st;
        @(posedge i_mclk) i_edge_trigger_pin <= 0;
        cyc(2);
        i_edge_trigger_pin <= 1;
        @(posedge i_mclk) i_edge_trigger_pin <= 0;
        wait_idle();
        chk("falling edge start", n_st - s, 1);
        wr(8'h97, 8'h16);
        s = n_st;
        @(posedge i_mclk) i_edge_trigger_pin <= 1;
        wait_idle();
        i_edge_trigger_pin <= 0;
        cyc(4);
        chk("rising edge start", n_st - s, 1);
        dly <= 8'h03;
        $display("test triggers done");
    endtask

    task automatic t_irq();
        i_irq_global <= 1;
        i_idle <= 1;
        wr(8'h97, 8'h45);
        wait_idle();
        chk("complete irq", o_irq, 1);
        chk("wake from idle", o_wake, 1);
        wr(8'h97, 8'h44);
        cyc(2);
        chk("irq after clear", o_irq, 0);
        i_idle <= 0;
        bnd_req <= 1;
        wr(8'h97, 8'h85);
        wait_idle();
        rdc("boundary flag", 8'hc0, 8'h80);
        chk("boundary irq", o_irq, 1);
        bnd_req <= 0;
        wr(8'hc0, 8'h00);
        rdc("boundary clear", 8'hc0, 8'h00);
        wr(8'h97, 8'h04);
        i_irq_global <= 0;
        $display("test interrupts done");
    endtask

    task automatic t_dac();
        int n;
        wr(adk_pkg::IDX_FOURTH_RES, 8'ha5);
        wr(8'ha1, 8'h08);
        cyc(2);
        chk("dac enable", o_dac_en, 1);
        chk("dac value", o_dac_value, 8'ha5);
        @(posedge i_mclk) i_pdown <= 1;
        s = n_st;
        wr(8'h97, 8'h05);
        cyc(4);
        chk("dac in power-down", o_dac_en, 0);
        chk("no start in power-down", n_st - s, 0);
        i_pdown <= 0;
        wr(8'h97, 8'h00);
        cyc(2);
        chk("dac without enable", o_dac_en, 0);
        wr(8'h97, 8'h04);
        foreach (dly[d]) if (d == 0 || d == 3 || d == 7) begin
            wr(8'ha1, 8'(d << 5));
            // ticks from the old divisor can still be in flight; let them pass
            cyc(16);
            wait_tick(n);
            wait_tick(n);
            chk("divider spacing", n, d + 1);
        end
        cyc(2);
        chk("dac select off", o_dac_en, 0);
        $display("test dac and divider done");
    endtask

    task automatic t_pins();
        wr(8'h97, 8'h00);
        wr(8'ha3, 8'h90);
        cyc(2);
        chk("inputs kept", o_dig_in_off, 4'h0);
        wr(8'h97, 8'h04);
        cyc(2);
        chk("inputs cut", o_dig_in_off, 4'h9);
        for (int i = 0; i < 4; i++) begin
            wr(8'hc0, (i < 3) ? 8'(8'h10 << i) : 8'h00);
            cyc(2);
            chk("conv mode", o_conv_mode, (i < 3) ? (1 << i) : 0);
        end
        // a continuous mode keeps the sequencer running past completion
        wr(8'hc0, 8'h40);
        wr(8'h97, 8'h05);
        cyc(12);
        chk("continuous busy", o_busy, 1);
        rdc("status run", 8'hf1, 8'h02);
        wr(8'hc0, 8'h00);
        wait_idle();
        chk("continuous left", o_busy, 0);
        $display("test pins and modes done");
    endtask

    initial begin
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1;
        t_reset();
        t_now();
        t_trig();
        t_irq();
        t_dac();
        t_pins();
        stop_test();
    end

    // watchdog against a hang anywhere in the sequence
    initial begin
        repeat (50000) @(posedge i_mclk);
        n_errors++;
        stop_test();
    end
endmodule // adk_ctrl_bench
